/* rtl/flash_cmd_pkg.sv */
`default_nettype none
package flash_cmd_pkg;

  // Command codes, shifted in most significant bit first.
  localparam logic [7:0] OP_WRSTAT = 8'h01;
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_RDSTAT = 8'h05;
  localparam logic [7:0] OP_FAST   = 8'h0b;

  // Bit counter marks, counted from the first opcode bit.
  localparam logic [5:0] OPC_LAST   = 6'h07;
  localparam logic [5:0] ADDR_LAST  = 6'h1f;
  localparam logic [5:0] DUMMY_LAST = 6'h27;
  localparam logic [5:0] WS_BITS    = 6'h10;
  localparam logic [5:0] CNT_MAX    = 6'h3f;
  localparam logic [2:0] BYTE_LAST  = 3'h7;

  // Self-timed status write, typical and longest time.
  localparam int CLK_MHZ       = 50;
  localparam int WS_TYP_US     = 5000;
  localparam int WS_MAX_US     = 15000;
  localparam int WS_TYP_CYCLES = WS_TYP_US * CLK_MHZ;
  localparam int WS_MAX_CYCLES = WS_MAX_US * CLK_MHZ;
  localparam int WS_CNT_W      = 20;

  // Density variants, named by sector count.
  typedef enum logic [1:0] {
    VAR_8S   = 2'h0,
    VAR_32S  = 2'h1,
    VAR_64S  = 2'h2,
    VAR_128S = 2'h3
  } variant_t;

  localparam logic [23:0] AMASK_8S   = 24'h07ffff;
  localparam logic [23:0] AMASK_32S  = 24'h1fffff;
  localparam logic [23:0] AMASK_64S  = 24'hffffff;
  localparam logic [23:0] AMASK_128S = 24'h7fffff;
  localparam int          SHIFT_64K  = 16;
  localparam int          SHIFT_256K = 18;
  localparam logic [8:0]  NSEC_8     = 9'h008;
  localparam logic [8:0]  NSEC_32    = 9'h020;
  localparam logic [8:0]  NSEC_64    = 9'h040;
  localparam logic [8:0]  NSEC_128   = 9'h080;
  localparam logic [2:0]  PROT_NONE  = 3'h0;
  localparam logic [2:0]  PROT_ALL   = 3'h7;

  typedef struct packed {
    logic [2:0] unused;
    logic [2:0] protect;
    logic       wel;
    logic       wip;
  } status_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } link_t;

  localparam logic [2:0] LINK_IDLE = 3'h4;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR   = 7'h04,
    ST_DUMMY  = 7'h08,
    ST_DATA   = 7'h10,
    ST_WSDATA = 7'h20,
    ST_IGNORE = 7'h40
  } state_t;

endpackage : flash_cmd_pkg
`default_nettype wire

/* rtl/link_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  // Two flops; the first is read only by the second to let metastability settle.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : link_sync
`default_nettype wire

/* rtl/sector_guard.sv */
`timescale 1ns/1ps
`default_nettype none
module sector_guard (
  input  wire flash_cmd_pkg::variant_t variant_in,
  input  wire logic [2:0]              code_in,
  input  wire logic [23:0]             addr_in,
  output logic      [23:0]             addr_mask_out,
  output logic                         protected_out
);
  logic [23:0] addr_m;
  logic [7:0]  sector;
  logic [8:0]  nsec;
  logic [2:0]  span_exp;
  logic [8:0]  span;

  // Unused upper address bits are don't-care for each density.
  assign addr_mask_out = (variant_in == flash_cmd_pkg::VAR_8S)  ? flash_cmd_pkg::AMASK_8S  :
                         (variant_in == flash_cmd_pkg::VAR_32S) ? flash_cmd_pkg::AMASK_32S :
                         (variant_in == flash_cmd_pkg::VAR_64S) ? flash_cmd_pkg::AMASK_64S :
                                                                  flash_cmd_pkg::AMASK_128S;
  assign addr_m = addr_in & addr_mask_out;
  assign sector = (variant_in == flash_cmd_pkg::VAR_64S) ? 8'(addr_m >> flash_cmd_pkg::SHIFT_256K)
                                                         : 8'(addr_m >> flash_cmd_pkg::SHIFT_64K);
  assign nsec   = (variant_in == flash_cmd_pkg::VAR_8S)  ? flash_cmd_pkg::NSEC_8  :
                  (variant_in == flash_cmd_pkg::VAR_32S) ? flash_cmd_pkg::NSEC_32 :
                  (variant_in == flash_cmd_pkg::VAR_64S) ? flash_cmd_pkg::NSEC_64 : flash_cmd_pkg::NSEC_128;

  // Each code step doubles the protected top span; the 128-sector part starts at two sectors.
  // A span that reaches the sector count covers everything, which is how code 6 of the 32-sector
  // part and codes 4 to 6 of the 8-sector part fold into full protection.
  assign span_exp = (variant_in == flash_cmd_pkg::VAR_128S) ? code_in : 3'(code_in - 3'h1);
  assign span     = 9'h001 << span_exp;
  assign protected_out = (code_in == flash_cmd_pkg::PROT_NONE) ? 1'b0 :
                         (code_in == flash_cmd_pkg::PROT_ALL)  ? 1'b1 :
                         (({1'b0, sector} + span) >= nsec);
endmodule : sector_guard
`default_nettype wire

/* rtl/serial_flash_protect_status_read.sv */
// Behaviour
// - 32-sector part: codes 1..5 guard top 1,2,4,8,16 sectors; 6 and 7 guard all.
// - 128-sector part: codes 1..6 guard top 2..64 sectors; 7 guards all.
// - 64-sector part: codes 1..6 guard top 1..32 sectors; 7 guards all.
// - Status read is always served, even while a timed cycle runs.
// - Status bit 0 shows the write-in-progress flag.
// - Opcode 01h plus one byte writes only the protect bits.
// - Guarded sectors are read-only; program and erase are refused there.
// - Status write needs chip select to rise right after the eighth data bit.
// - The timed status write starts at chip select rise, 5 ms typical, under 15 ms.
// - Write-in-progress reads 1 throughout the timed cycle and 0 after it.
// - Read opcode 03h plus 24-bit address, sampled on rising serial clock.
// - Data goes out msb first, changing on falling serial clock.
// - Normal read steps the address per byte and wraps to zero.
// - Chip select rise during output stops driving and returns to idle.
// - Normal read during a timed cycle is ignored; the cycle goes on.
// - Fast read opcode 0Bh, 24-bit address and one dummy byte precede data.
// - Fast read data changes on falling edges; host may clock up to 40 MHz; here each clock level must last a 50 MHz core cycle.
// - Fast read steps and wraps the address and ends on chip select rise.
// - Fast read during a timed cycle is rejected without disturbing it.
// - Unused upper address bits are ignored for each density.
// - Write-enable latch sits at status bit 1 and gates the status write.
// - Write-enable latch clears when the status write cycle completes.
// - Bulk erase is allowed only with all protect bits zero.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_protect_status_read #(
  parameter int WS_CYCLES = flash_cmd_pkg::WS_TYP_CYCLES
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    chip_select_n_in,
  input  wire logic                    serial_clock_in,
  input  wire logic                    serial_data_in,
  input  wire flash_cmd_pkg::variant_t variant_in,
  input  wire logic                    wip_ext_in,
  input  wire logic                    wel_set_in,
  input  wire logic                    wel_clr_in,
  input  wire logic [23:0]             check_addr_in,
  input  wire logic [7:0]              array_data_in,
  output logic                         serial_data_out,
  output logic                         serial_data_oe_out,
  output logic [23:0]                  array_addr_out,
  output logic                         array_rd_out,
  output logic [7:0]                   status_out,
  output logic                         write_protected_out,
  output logic                         bulk_erase_ok_out
);
  localparam int              WS_W    = flash_cmd_pkg::WS_CNT_W;
  localparam logic [WS_W-1:0] WS_LAST = WS_W'(WS_CYCLES - 1);

  flash_cmd_pkg::link_t   link_raw;
  flash_cmd_pkg::link_t   link_s;
  flash_cmd_pkg::link_t   link_p_q;
  flash_cmd_pkg::state_t  state_q, state_d;
  flash_cmd_pkg::status_t status_now;
  flash_cmd_pkg::status_t ws_byte;
  logic [5:0]  bitcnt_q, bitcnt_d;
  logic [7:0]  shin_q, shin_d;
  logic [23:0] addr_q, addr_d;
  logic [7:0]  obyte_q, obyte_d;
  logic [2:0]  obit_q, obit_d;
  logic        fast_q, fast_d;
  logic        stat_q, stat_d;
  logic        sdo_q, sdo_d;
  logic        oe_q, oe_d;
  logic        rd_d, cap_q;
  logic [23:0] raddr_q, raddr_d;
  logic        ws_busy_q, ws_start, ws_done;
  logic [flash_cmd_pkg::WS_CNT_W-1:0] ws_cnt_q;
  logic [2:0]  ws_data_q, protect_q;
  logic        wel_q;
  logic        busy;
  logic [23:0] amask;
  logic        guard_hit;
  logic        sck_rise, sck_fall, cs_rise, cs_fall;

  // Every link pin is resynchronised before any decode looks at it.
  assign link_raw = '{cs_n: chip_select_n_in, sclk: serial_clock_in, sdi: serial_data_in};

  link_sync #(
    .WIDTH   (3),
    .RST_VAL (flash_cmd_pkg::LINK_IDLE)
  ) u_sync (
    .clk_in  (core_clk_in),
    .rstn_in (rstn_in),
    .d_in    (link_raw),
    .q_out   (link_s)
  );

  // Edges are found against a delayed copy of the synchronised pins.
  assign sck_rise = link_s.sclk & ~link_p_q.sclk & ~link_s.cs_n;
  assign sck_fall = ~link_s.sclk & link_p_q.sclk & ~link_s.cs_n;
  assign cs_rise  = link_s.cs_n & ~link_p_q.cs_n;
  assign cs_fall  = ~link_s.cs_n & link_p_q.cs_n;

  // The status byte is assembled live so a read during a timed cycle sees it.
  assign busy       = ws_busy_q | wip_ext_in;
  assign status_now = '{unused: 3'h0, protect: protect_q, wel: wel_q, wip: busy};
  assign ws_byte    = shin_q; // Last shifted byte viewed as a status word.

  // The same guard serves program/erase checks and the address width mask.
  sector_guard u_guard (
    .variant_in    (variant_in),
    .code_in       (protect_q),
    .addr_in       (check_addr_in),
    .addr_mask_out (amask),
    .protected_out (guard_hit)
  );

  // A status write is only taken with exactly sixteen bits, the latch set and no cycle running.
  assign ws_start = cs_rise && (state_q == flash_cmd_pkg::ST_WSDATA) && (bitcnt_q == flash_cmd_pkg::WS_BITS)
                    && wel_q && !busy;
  assign ws_done  = ws_busy_q && (ws_cnt_q == WS_LAST);

  // Command sequencer; chip select edges take priority over serial clock edges.
  always_comb begin
    state_d  = state_q;
    bitcnt_d = bitcnt_q;
    shin_d   = shin_q;
    addr_d   = addr_q;
    obyte_d  = obyte_q;
    obit_d   = obit_q;
    fast_d   = fast_q;
    stat_d   = stat_q;
    sdo_d    = sdo_q;
    oe_d     = oe_q;
    rd_d     = 1'b0;
    raddr_d  = raddr_q;
    if (cs_rise) begin
      state_d = flash_cmd_pkg::ST_IDLE;
      oe_d    = 1'b0;
    end else if (cs_fall) begin
      state_d  = flash_cmd_pkg::ST_OPCODE;
      bitcnt_d = 6'h00;
    end else if (sck_rise) begin
      shin_d = {shin_q[6:0], link_s.sdi};
      if (bitcnt_q != flash_cmd_pkg::CNT_MAX) begin
        bitcnt_d = 6'(bitcnt_q + 6'h01);
      end
      case (state_q)
        flash_cmd_pkg::ST_OPCODE: begin
          if (bitcnt_q == flash_cmd_pkg::OPC_LAST) begin
            fast_d = (shin_d == flash_cmd_pkg::OP_FAST);
            stat_d = (shin_d == flash_cmd_pkg::OP_RDSTAT);
            obit_d = 3'h0;
            if (shin_d == flash_cmd_pkg::OP_RDSTAT) begin
              state_d = flash_cmd_pkg::ST_DATA;
              obyte_d = status_now;
            end else if ((shin_d == flash_cmd_pkg::OP_READ || shin_d == flash_cmd_pkg::OP_FAST) && !busy) begin
              state_d = flash_cmd_pkg::ST_ADDR;
            end else if (shin_d == flash_cmd_pkg::OP_WRSTAT && !busy) begin
              state_d = flash_cmd_pkg::ST_WSDATA;
            end else begin
              state_d = flash_cmd_pkg::ST_IGNORE;
            end
          end
        end
        flash_cmd_pkg::ST_ADDR: begin
          addr_d = {addr_q[22:0], link_s.sdi} & amask;
          if (bitcnt_q == flash_cmd_pkg::ADDR_LAST) begin
            if (fast_q) begin
              state_d = flash_cmd_pkg::ST_DUMMY;
            end else begin
              state_d = flash_cmd_pkg::ST_DATA;
              rd_d    = 1'b1;
              raddr_d = addr_d;
            end
          end
        end
        flash_cmd_pkg::ST_DUMMY: begin
          if (bitcnt_q == flash_cmd_pkg::DUMMY_LAST) begin
            state_d = flash_cmd_pkg::ST_DATA;
            rd_d    = 1'b1;
            raddr_d = addr_q;
          end
        end
        default: begin
        end
      endcase
    end else if (sck_fall && state_q == flash_cmd_pkg::ST_DATA) begin
      sdo_d   = obyte_q[7];
      oe_d    = 1'b1;
      obyte_d = {obyte_q[6:0], 1'b0};
      obit_d  = 3'(obit_q + 3'h1);
      if (obit_q == flash_cmd_pkg::BYTE_LAST) begin
        if (stat_q) begin
          obyte_d = status_now;
        end else begin
          addr_d  = 24'(addr_q + 24'h000001) & amask;
          rd_d    = 1'b1;
          raddr_d = addr_d;
        end
      end
    end
    // Array data returns one cycle after the fetch strobe and is taken in the cycle after, well before the next falling edge.
    if (cap_q) begin
      obyte_d = array_data_in;
    end
  end

  // Link-side sequencer state.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_p_q <= flash_cmd_pkg::LINK_IDLE;
      state_q  <= flash_cmd_pkg::ST_IDLE;
      bitcnt_q <= 6'h00;
      shin_q   <= 8'h00;
      addr_q   <= 24'h000000;
      obyte_q  <= 8'h00;
      obit_q   <= 3'h0;
      fast_q   <= 1'b0;
      stat_q   <= 1'b0;
      sdo_q    <= 1'b0;
      oe_q     <= 1'b0;
      raddr_q  <= 24'h000000;
    end else begin
      link_p_q <= link_s;
      state_q  <= state_d;
      bitcnt_q <= bitcnt_d;
      shin_q   <= shin_d;
      addr_q   <= addr_d;
      obyte_q  <= obyte_d;
      obit_q   <= obit_d;
      fast_q   <= fast_d;
      stat_q   <= stat_d;
      sdo_q    <= sdo_d;
      oe_q     <= oe_d;
      raddr_q  <= raddr_d;
    end
  end

  // Fetch strobe and its capture one cycle later.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      array_rd_out <= 1'b0;
      cap_q        <= 1'b0;
    end else begin
      array_rd_out <= rd_d;
      cap_q        <= array_rd_out;
    end
  end

  // Timed status write; protect bits change only when the cycle completes.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ws_busy_q <= 1'b0;
      ws_cnt_q  <= '0;
      ws_data_q <= flash_cmd_pkg::PROT_NONE;
      protect_q <= flash_cmd_pkg::PROT_NONE;
    end else if (ws_start) begin
      ws_busy_q <= 1'b1;
      ws_cnt_q  <= '0;
      ws_data_q <= ws_byte.protect;
    end else if (ws_done) begin
      ws_busy_q <= 1'b0;
      protect_q <= ws_data_q;
    end else if (ws_busy_q) begin
      ws_cnt_q <= ws_cnt_q + WS_W'(1);
    end
  end

  // The latch is set by the neighbouring write-enable logic; a set beats a same-cycle clear.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wel_q <= 1'b0;
    end else if (wel_set_in) begin
      wel_q <= 1'b1;
    end else if (wel_clr_in || ws_done) begin
      wel_q <= 1'b0;
    end
  end

  // Registered outputs toward the pins and the neighbouring program/erase logic.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_out          <= 8'h00;
      write_protected_out <= 1'b0;
      bulk_erase_ok_out   <= 1'b0;
      array_addr_out      <= 24'h000000;
    end else begin
      status_out          <= status_now;
      write_protected_out <= guard_hit;
      bulk_erase_ok_out   <= (protect_q == flash_cmd_pkg::PROT_NONE);
      array_addr_out      <= raddr_d;
    end
  end

  assign serial_data_out    = sdo_q;
  assign serial_data_oe_out = oe_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  a_wip_reported: assert property ($rose(ws_busy_q) |=> status_out[0])
    else $error("wip not shown while status write runs");
  a_ws_needs_wel: assert property ($rose(ws_busy_q) |-> $past(wel_q) && $past(cs_rise))
    else $error("status write started without latch or chip select rise");
  a_ws_bit_count: assert property ($rose(ws_busy_q) |-> $past(bitcnt_q) == flash_cmd_pkg::WS_BITS)
    else $error("status write started at wrong bit count");
  a_ws_holds: assert property ($rose(ws_busy_q) |-> ws_busy_q[*8])
    else $error("status write cycle too short");
  a_wel_clears: assert property ($fell(ws_busy_q) |-> !wel_q || $past(wel_set_in))
    else $error("latch not cleared at status write end");
  a_protect_only: assert property ($changed(protect_q) |-> $past(ws_done))
    else $error("protect bits changed outside status write");
  a_read_reject: assert property (sck_rise && state_q == flash_cmd_pkg::ST_OPCODE
      && bitcnt_q == flash_cmd_pkg::OPC_LAST && busy && shin_d != flash_cmd_pkg::OP_RDSTAT
      |=> state_q == flash_cmd_pkg::ST_IGNORE)
    else $error("command accepted while busy");
  a_cs_stop: assert property (cs_rise |=> !serial_data_oe_out && state_q == flash_cmd_pkg::ST_IDLE)
    else $error("output still driven after chip select rise");
  a_new_cmd: assert property (cs_fall |=> state_q == flash_cmd_pkg::ST_OPCODE && bitcnt_q == 6'h00)
    else $error("chip select fall did not restart decoder");
  a_out_on_fall: assert property ($changed(serial_data_out) |-> $past(sck_fall))
    else $error("data out changed off a falling edge");
  a_addr_wrap: assert property ($past(sck_fall) && $past(state_q) == flash_cmd_pkg::ST_DATA && !$past(stat_q)
      && $past(obit_q) == flash_cmd_pkg::BYTE_LAST && $past(addr_q) == amask |-> addr_q == 24'h000000)
    else $error("address did not wrap to zero");
  a_bulk_ok: assert property ($past(rstn_in)
      |-> bulk_erase_ok_out == ($past(protect_q) == flash_cmd_pkg::PROT_NONE))
    else $error("bulk erase permission wrong");
endmodule : serial_flash_protect_status_read
`default_nettype wire

/* verif/flash_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input  wire logic sdo_in,
  input  wire logic oe_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  localparam int HALF = 80;
  logic          line_seen;

  // With the output released the line must not keep showing a stale bit.
  assign line_seen = oe_in ? sdo_in : ~sdo_in;

  // The link idles deselected with the serial clock parked low.
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out  = 1'b0;
  end

  // One framed command in mode 0: header msb first, then nb bytes sampled on rising edges.
  // The last header bit is held high for a long time so the device can fetch its first byte.
  task automatic frame(input logic [39:0] hdr, input int nh, input int nb,
                       output logic [31:0] rx, output int oe_n);
    rx = '0;
    oe_n = 0;
    #7 cs_n_out = 1'b0;
    for (int i = 0; i < nh + nb * 8; i++) begin
      sdi_out = (i < nh) ? hdr[39-i] : i[0];
      #HALF sclk_out = 1'b1;
      if (i >= nh) begin
        rx = {rx[30:0], line_seen};
        oe_n += int'(oe_in);
      end
      #((i == nh - 1) ? 10 * HALF : HALF) sclk_out = 1'b0;
    end
    #HALF cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    // Keep the device deselected long enough for its synchroniser to see the rise.
    #(2 * HALF);
  endtask : frame
endmodule : flash_host_model
`default_nettype wire

/* verif/test_serial_flash_protect_status_read.sv */
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_protect_status_read;
  localparam int WS = 400;
  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  logic                    cs_n, sclk, sdi, sdo, oe, array_rd, wprot, beok;
  logic                    wip_ext = 1'b0, wel_set = 1'b0, wel_clr = 1'b0;
  flash_cmd_pkg::variant_t variant = flash_cmd_pkg::VAR_8S;
  logic [23:0]             check_addr = 24'h0, array_addr;
  logic [7:0]              array_data = 8'h00, status, s;
  logic [31:0]             rx;
  int                      n, num_errors = 0, checks_done = 0, cycles = 0;

  always #10 clk = ~clk;

  // Bytes depend on the low and top address bytes so a wrong wrap or mask shows up.
  function automatic logic [7:0] ex(input logic [23:0] a);
    return a[7:0] + a[23:16] + 8'h11;
  endfunction : ex

  // Synchronous array stand-in answering one cycle after each fetch.
  always @(posedge clk) if (array_rd) array_data <= ex(array_addr);

  flash_host_model host (.sdo_in(sdo), .oe_in(oe), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi));

  serial_flash_protect_status_read #(.WS_CYCLES(WS)) uut (
    .core_clk_in(clk), .rstn_in(rstn), .chip_select_n_in(cs_n), .serial_clock_in(sclk),
    .serial_data_in(sdi), .variant_in(variant), .wip_ext_in(wip_ext), .wel_set_in(wel_set),
    .wel_clr_in(wel_clr), .check_addr_in(check_addr), .array_data_in(array_data),
    .serial_data_out(sdo), .serial_data_oe_out(oe), .array_addr_out(array_addr),
    .array_rd_out(array_rd), .status_out(status), .write_protected_out(wprot),
    .bulk_erase_ok_out(beok));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // A hung handshake must not stall the run forever.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      $display("timeout waiting on the device");
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // Set and clear pulses stand in for the neighbouring enable and disable commands.
  task automatic pulse(input bit set);
    wel_set = set;
    wel_clr = !set;
    tick(1);
    wel_set = 1'b0;
    wel_clr = 1'b0;
    tick(3);
  endtask : pulse

  task automatic wstat(input logic [7:0] d, input int nh);
    host.frame({8'h01, d, 24'h0}, nh, 0, rx, n);
    tick(6);
  endtask : wstat

  // Poll with a bound; the self-timed cycle must end well inside it.
  task automatic wait_idle();
    for (int k = 0; k < WS + 40 && status[0] !== 1'b0; k++) tick(1);
    chk("wip clear", 0, status[0]);
  endtask : wait_idle

  task automatic rd_status(input int nb);
    host.frame({8'h05, 32'h0}, 8, nb, rx, n);
    tick(6);
  endtask : rd_status

  function automatic int nprot(int v, int c);
    if (c == 0) return 0;
    if (v == 3) return (c == 7) ? 128 : 2 << (c - 1);
    if (v == 2) return (c == 7) ? 64 : 1 << (c - 1);
    return (c >= 6) ? 32 : 1 << (c - 1);
  endfunction : nprot

  initial begin
    int ns, sz, lo;
    tick(6);
    rstn = 1'b1;
    tick(5);
    chk("status after reset", 8'h00, status);
    chk("bulk erase ok", 1, beok);
    wstat(8'h1c, 16);
    tick(WS + 10);
    chk("unlatched write", 8'h00, status);
    $display("test reset and refusal done");
    pulse(1'b1);
    chk("latch set", 8'h02, status);
    wstat(8'h14, 16);
    chk("busy flags", 8'h03, status);
    rd_status(1);
    chk("status read busy", 8'h03, rx);
    wait_idle();
    chk("protect written", 8'h14, status);
    chk("bulk erase refused", 0, beok);
    rd_status(2);
    chk("status repeats", 32'h1414, rx);
    pulse(1'b1);
    wstat(8'h00, 15);
    tick(WS + 10);
    chk("short write dropped", 8'h16, status);
    pulse(1'b0);
    chk("latch cleared", 8'h14, status);
    $display("test status write done");
    // Walk every protect code down to zero and probe both sides of each boundary on the 32-, 64- and 128-sector parts.
    for (int c = 7; c >= 0; c--) begin
      pulse(1'b1);
      wstat({3'h0, c[2:0], 2'h0}, 16);
      wait_idle();
      chk("code written", {3'h0, c[2:0], 2'h0}, status);
      for (int v = 1; v < 4; v++) begin
        variant = flash_cmd_pkg::variant_t'(v[1:0]);
        ns = (v == 3) ? 128 : (v == 2) ? 64 : 32;
        sz = (v == 2) ? 32'h40000 : 32'h10000;
        lo = (ns - nprot(v, c)) * sz;
        check_addr = 24'(lo);
        tick(2);
        chk("guard low edge", (nprot(v, c) > 0), wprot);
        check_addr = 24'(lo - 1);
        tick(2);
        chk("guard below", (nprot(v, c) == ns) && (lo == 0), wprot);
      end
    end
    chk("bulk erase back", 1, beok);
    $display("test protect decode done");
    variant = flash_cmd_pkg::VAR_8S;
    host.frame({8'h03, 24'hf7fffe, 8'h00}, 32, 4, rx, n);
    chk("read wrap", {ex(24'h07fffe), ex(24'h07ffff), ex(24'h0), ex(24'h1)}, rx);
    chk("read drive", 32, n);
    tick(6);
    chk("released", 0, oe);
    variant = flash_cmd_pkg::VAR_64S;
    host.frame({8'h0b, 24'hffffff, 8'ha5}, 40, 2, rx, n);
    chk("fast wrap", {ex(24'hffffff), ex(24'h0)}, rx);
    variant = flash_cmd_pkg::VAR_32S;
    host.frame({8'h0b, 24'h3fffff, 8'h5a}, 40, 2, rx, n);
    chk("fast mask", {ex(24'h1fffff), ex(24'h0)}, rx);
    $display("test array reads done");
    wip_ext = 1'b1;
    host.frame({8'h03, 24'h000010, 8'h00}, 32, 2, rx, n);
    chk("read while busy", 0, n);
    host.frame({8'h0b, 24'h000010, 8'h00}, 40, 2, rx, n);
    chk("fast while busy", 0, n);
    rd_status(1);
    chk("status while busy", 8'h01, rx);
    wip_ext = 1'b0;
    tick(3);
    chk("idle again", 8'h00, status);
    $display("test busy refusal done");
    complete_run();
  end
endmodule : test_serial_flash_protect_status_read
`default_nettype wire
